// >>> core/dtc_timer.sv
// dual timer/counter with run/flag control register and overflow toggle pins
// How it works
// - mode 0 is 13 bits, 5-bit prescaler under 8-bit high byte, flag on wrap.
// - outside unit 0 split, a unit advances only when run is set and gate is clear or irq pin high.
// - mode 0 uses high byte and low 5 bits; low byte upper 3 bits left alone.
// - setting run resumes counting and never clears the count bytes.
// - each unit has its own gate bit, unit 1 at bit 7, unit 0 at bit 3.
// - mode 1 is a plain 16-bit cascade without prescaler.
// - mode 2 low byte counts, on overflow sets flag and reloads from high byte.
// - unit 1 in mode 3 is stopped as if its run bit were clear.
// - unit 0 mode 3 splits into low counter and high timer using unit 1 run/flag.
// - then unit 1 runs by leaving mode 3 and never sets its flag.
// - mode 6 is a 256-clock PWM built like the 8-bit mode.
// - in mode 6 the flag is low for high-byte clocks; software keeps 1..254.
// - in mode 6 hardware drives the flag, high for 256 minus high byte clocks.
// - in mode 6 high byte 00h forces the pin high, FFh forces it low.
// - in mode 6 the flag rises per period; while counting, software writes and acks cannot clear it.
// - run bits at 4 and 6 of the control register, all bits reset zero.
// - overflow flags at 5 and 7 set by hardware, cleared by ack or software.
// - type bits 0 and 2 pick falling edge when set, low level when clear.
// - edge flags 1 and 3 set on detection, cleared by ack or software.
// - outside mode 6, with toggle enable set, each overflow of a unit's counting step inverts its pin; the split high byte overflow toggles none.
// - outside mode 6, turning toggling on drives the pin high until the first overflow.
// - mode field 000..011 are modes 0..3, 110 is PWM, the rest reserved.
// - select clear counts the cpu clock, set counts external pin events.
`default_nettype none
module dtc_timer (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// register port
	input  wire dtc_pkg::dtc_bus_type bus,
	output logic [7:0]            rdata,
	// interrupt controller
	input  wire dtc_pkg::dtc_ack_type ack,
	output logic [7:0]            ctl_flags,
	// pins
	input  wire logic [1:0]       ext_irq_pin,
	input  wire logic [1:0]       tpin_in,
	output logic [1:0]            tpin_out,
	output logic [1:0]            tpin_oe
);
	import dtc_pkg::*;

	// mode field decode, used for both units
	function automatic dtc_mode_type mode_of(input logic m2, input logic [1:0] m10);
		mode_of = dtc_mode_type'({m2, m10});
	endfunction : mode_of

	// one counting step for a unit in its own mode
	function automatic dtc_cnt_type step(input dtc_mode_type m, input logic [7:0] lo,
			input logic [7:0] hi, input logic tk);
		dtc_cnt_type r;
		r = '{lo: lo, hi: hi, ovf: 1'b0};
		if (tk) begin
			case (m)
				DTC_M0: begin
					// upper 3 bits of the low byte are never touched
					r.lo[4:0] = lo[4:0] + 5'h01;
					if (lo[4:0] == DTC_PRE_MAX) begin
						r.hi  = hi + 8'h01;
						r.ovf = (hi == DTC_BYTE_MAX);
					end
				end
				DTC_M1: begin
					{r.hi, r.lo} = {hi, lo} + 16'h0001;
					r.ovf = ({hi, lo} == {DTC_BYTE_MAX, DTC_BYTE_MAX});
				end
				DTC_M2: begin
					r.lo  = (lo == DTC_BYTE_MAX) ? hi : lo + 8'h01;
					r.ovf = (lo == DTC_BYTE_MAX);
				end
				DTC_M3, DTC_PWM: begin
					// pwm wraps freely so the period stays 256 clocks
					r.lo  = lo + 8'h01;
					r.ovf = (lo == DTC_BYTE_MAX);
				end
				default: r.ovf = 1'b0;
			endcase
		end
		step = r;
	endfunction : step

	// state
	logic [7:0]   ctl_q;
	logic [7:0]   mode_q;
	logic [1:0]   aux_mode_q;
	logic [1:0]   tog_q;
	logic [7:0]   lo_q [2];
	logic [7:0]   hi_q [2];
	logic [1:0]   sync1_q;
	logic [1:0]   sync2_q;
	logic [1:0]   sync3_q;
	logic [1:0]   irq_prev_q;
	logic [1:0]   out_q;
	logic [7:0]   rdata_q;

	// next values and decode
	logic [7:0]   ctl_d;
	logic [7:0]   lo_d [2];
	logic [7:0]   hi_d [2];
	logic [1:0]   out_d;
	dtc_mode_type mode [2];
	dtc_cnt_type  stp [2];
	logic [1:0]   run;
	logic [1:0]   gate;
	logic [1:0]   ct_sel;
	logic [1:0]   src;
	logic [1:0]   gate_open;
	logic [1:0]   tick;
	logic [1:0]   pwm;
	logic [1:0]   pwm_lvl;
	logic [1:0]   ovf_set;
	logic [1:0]   pwm_owns;
	logic [1:0]   ie_set;
	logic [1:0]   wr_lo;
	logic [1:0]   wr_hi;
	logic [1:0]   turn_on;
	logic         wr_ctl;
	logic         wr_mode;
	logic         wr_auxm;
	logic         wr_tog;
	logic         u0_split;
	logic         hi3_tick;
	logic         hi3_ovf;
	logic [7:0]   rd_sel;

	// register port write decode
	assign wr_ctl  = bus.wr && (bus.addr == DTC_A_CTL);
	assign wr_mode = bus.wr && (bus.addr == DTC_A_MODE);
	assign wr_auxm = bus.wr && (bus.addr == DTC_A_AUXM);
	assign wr_tog  = bus.wr && (bus.addr == DTC_A_TOG);

	// unit 0 split mode steals unit 1 run bit and flag
	assign u0_split = (mode[0] == DTC_M3);
	assign hi3_tick = u0_split && run[1];
	assign hi3_ovf  = hi3_tick && (hi_q[0] == DTC_BYTE_MAX);

	// unit 1 ignores run and gate while unit 0 is split; only its own mode 3 stops it
	assign tick[0] = gate_open[0] && src[0];
	assign tick[1] = src[1] && (mode[1] != DTC_M3)
		&& (u0_split || gate_open[1]);

	// flag sources: unit 1 counter never reaches the flag while unit 0 is split
	assign ovf_set[0]  = stp[0].ovf;
	assign ovf_set[1]  = u0_split ? hi3_ovf : stp[1].ovf;
	assign pwm_owns[0] = pwm[0] && tick[0];
	assign pwm_owns[1] = pwm[1] && tick[1] && !u0_split;

	// per-unit logic
	for (genvar u = 0; u < 2; u++) begin : g_unit
		localparam int CB = DTC_CTL_STRIDE * u;
		localparam int MB = DTC_MODE_STRIDE * u;
		logic keep_ovf;
		logic keep_edge;

		assign mode[u]   = mode_of(aux_mode_q[u], mode_q[MB + DTC_B_MHI -: 2]);
		assign run[u]    = ctl_q[DTC_B_RUN + CB];
		assign gate[u]   = mode_q[DTC_B_GATE + MB];
		assign ct_sel[u] = mode_q[DTC_B_CT + MB];
		assign pwm[u]    = (mode[u] == DTC_PWM);

		// internal select counts every clock, external counts pin falling edges
		assign src[u]       = ct_sel[u] ? (sync3_q[u] && !sync2_q[u]) : 1'b1;
		assign gate_open[u] = run[u] && (!gate[u] || ext_irq_pin[u]);
		assign stp[u]       = step(mode[u], lo_q[u], hi_q[u], tick[u]);
		assign pwm_lvl[u]   = (stp[u].lo >= hi_q[u]);

		// byte writes win over counting in the same cycle
		assign wr_lo[u] = bus.wr && (bus.addr == 8'(DTC_A_LO0 + u));
		assign wr_hi[u] = bus.wr && (bus.addr == 8'(DTC_A_HI0 + u));
		assign lo_d[u]  = wr_lo[u] ? bus.wdata : stp[u].lo;
		if (u == 0) begin : g_hi0
			assign hi_d[u] = wr_hi[u] ? bus.wdata
				: (u0_split ? (hi3_tick ? hi_q[u] + 8'h01 : hi_q[u]) : stp[u].hi);
		end else begin : g_hi1
			assign hi_d[u] = wr_hi[u] ? bus.wdata : stp[u].hi;
		end

		// control bits: outside pwm, set by hardware wins over any clear in the same cycle
		assign keep_ovf  = (wr_ctl ? bus.wdata[DTC_B_OVF + CB] : ctl_q[DTC_B_OVF + CB])
			&& !ack.ovf[u];
		assign keep_edge = (wr_ctl ? bus.wdata[DTC_B_EDGE + CB] : ctl_q[DTC_B_EDGE + CB])
			&& !ack.edge_flag[u];
		assign ctl_d[DTC_B_TYPE + CB] = wr_ctl ? bus.wdata[DTC_B_TYPE + CB]
			: ctl_q[DTC_B_TYPE + CB];
		assign ctl_d[DTC_B_RUN + CB]  = wr_ctl ? bus.wdata[DTC_B_RUN + CB]
			: ctl_q[DTC_B_RUN + CB];
		assign ctl_d[DTC_B_OVF + CB]  = pwm_owns[u] ? pwm_lvl[u]
			: (ovf_set[u] || keep_ovf);
		assign ctl_d[DTC_B_EDGE + CB] = ie_set[u] || keep_edge;

		// edge type catches a falling pin, level type follows a low pin
		assign ie_set[u] = ctl_q[DTC_B_TYPE + CB] ? (irq_prev_q[u] && !ext_irq_pin[u])
			: !ext_irq_pin[u];

		// pin: high on enable, forced or flag-following in pwm, toggled on overflow
		assign turn_on[u] = wr_tog && bus.wdata[u] && !tog_q[u];
		assign out_d[u] = turn_on[u] ? 1'b1
			: pwm[u] ? ((hi_q[u] == DTC_PWM_HI) ? 1'b1
				: (hi_q[u] == DTC_PWM_LO) ? 1'b0 : pwm_lvl[u])
			: (tog_q[u] && stp[u].ovf) ? !out_q[u] : out_q[u];
	end

	// read selection; reserved and unmapped bits read zero
	assign rd_sel = (bus.addr == DTC_A_CTL)  ? ctl_q
		: (bus.addr == DTC_A_MODE) ? mode_q
		: (bus.addr == DTC_A_LO0)  ? lo_q[0]
		: (bus.addr == 8'(DTC_A_LO0 + 1)) ? lo_q[1]
		: (bus.addr == DTC_A_HI0)  ? hi_q[0]
		: (bus.addr == 8'(DTC_A_HI0 + 1)) ? hi_q[1]
		: (bus.addr == DTC_A_AUXM) ? {3'h0, aux_mode_q[1], 3'h0, aux_mode_q[0]}
		: (bus.addr == DTC_A_TOG)  ? {6'h00, tog_q}
		: DTC_RST;

	// software registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctl_q      <= DTC_RST;
			mode_q     <= DTC_RST;
			aux_mode_q <= 2'h0;
			tog_q      <= 2'h0;
		end else begin
			ctl_q <= ctl_d;
			if (wr_mode) mode_q <= bus.wdata;
			if (wr_auxm) aux_mode_q <= {bus.wdata[DTC_MODE_STRIDE], bus.wdata[0]};
			if (wr_tog) tog_q <= bus.wdata[1:0];
		end
	end

	// count bytes; the run bit only gates ticks, it never clears these
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			lo_q <= '{DTC_RST, DTC_RST};
			hi_q <= '{DTC_RST, DTC_RST};
		end else begin
			lo_q <= lo_d;
			hi_q <= hi_d;
		end
	end

	// pin history: three stages so the first stage feeds only the second
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sync1_q    <= 2'h3;
			sync2_q    <= 2'h3;
			sync3_q    <= 2'h3;
			irq_prev_q <= 2'h3;
			out_q      <= 2'h3;
		end else begin
			sync1_q    <= tpin_in;
			sync2_q    <= sync1_q;
			sync3_q    <= sync2_q;
			irq_prev_q <= ext_irq_pin;
			out_q      <= out_d;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!rst_n) rdata_q <= DTC_RST;
		else rdata_q <= bus.rd ? rd_sel : DTC_RST;
	end

	assign rdata     = rdata_q;
	assign ctl_flags = ctl_q;
	assign tpin_out  = out_q;
	assign tpin_oe   = tog_q | pwm;

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_m0_wrap;
		(mode[0] == DTC_M0) && tick[0] && (lo_q[0][4:0] == DTC_PRE_MAX)
		&& (hi_q[0] == DTC_BYTE_MAX) && !bus.wr
		|=> ctl_q[DTC_B_OVF] && (hi_q[0] == DTC_RST) && (lo_q[0][4:0] == 5'h00);
	endproperty
	a_m0_wrap: assert property (p_m0_wrap) else $error("mode 0 wrap lost");

	property p_stopped;
		// a split unit 0 lends its high byte to unit 1's run bit, so only the low byte must hold
		!run[0] && !bus.wr |=> $stable(lo_q[0]) && ($past(u0_split) || $stable(hi_q[0]));
	endproperty
	a_stopped: assert property (p_stopped) else $error("unit 0 moved while off");

	property p_m0_upper;
		(mode[0] == DTC_M0) && !bus.wr |=> lo_q[0][7:5] == $past(lo_q[0][7:5]);
	endproperty
	a_m0_upper: assert property (p_m0_upper) else $error("prescaler top bits moved");

	property p_m1_carry;
		(mode[1] == DTC_M1) && tick[1] && (lo_q[1] == DTC_BYTE_MAX) && !bus.wr
		|=> (hi_q[1] == $past(hi_q[1]) + 8'h01) && (lo_q[1] == DTC_RST);
	endproperty
	a_m1_carry: assert property (p_m1_carry) else $error("16-bit carry lost");

	property p_m2_reload;
		(mode[0] == DTC_M2) && tick[0] && (lo_q[0] == DTC_BYTE_MAX) && !bus.wr
		|=> (lo_q[0] == $past(hi_q[0])) && $stable(hi_q[0]) && ctl_q[DTC_B_OVF];
	endproperty
	a_m2_reload: assert property (p_m2_reload) else $error("auto reload wrong");

	property p_u1_m3_stop;
		(mode[1] == DTC_M3) && !bus.wr ##1 (mode[1] == DTC_M3) && !bus.wr
		|=> $stable(lo_q[1]) && $stable(hi_q[1]);
	endproperty
	a_u1_m3_stop: assert property (p_u1_m3_stop) else $error("unit 1 ran in mode 3");

	property p_split_hi;
		u0_split && run[1] && (hi_q[0] == DTC_BYTE_MAX) && !bus.wr
		|=> ctl_q[DTC_B_OVF + DTC_CTL_STRIDE] && (hi_q[0] == DTC_RST);
	endproperty
	a_split_hi: assert property (p_split_hi) else $error("split high byte flag lost");

	property p_pwm_force;
		pwm[0] && (hi_q[0] == DTC_PWM_LO) && !bus.wr ##1 pwm[0] |-> !tpin_out[0] && tpin_oe[0];
	endproperty
	a_pwm_force: assert property (p_pwm_force) else $error("pwm pin not forced low");

	property p_edge_set;
		ctl_q[DTC_B_TYPE] && irq_prev_q[0] && !ext_irq_pin[0] |=> ctl_q[DTC_B_EDGE];
	endproperty
	a_edge_set: assert property (p_edge_set) else $error("falling edge not flagged");

	property p_tog_on;
		turn_on[0] && !pwm[0] |=> tpin_out[0] && tpin_oe[0];
	endproperty
	a_tog_on: assert property (p_tog_on) else $error("toggle pin not high at enable");

	property p_run_keep;
		wr_ctl && bus.wdata[DTC_B_RUN] && !run[0] && !u0_split
		|=> (lo_q[0] == $past(lo_q[0])) && (hi_q[0] == $past(hi_q[0]));
	endproperty
	a_run_keep: assert property (p_run_keep) else $error("run start moved count");

	property p_pwm_flag;
		pwm_owns[0] && !bus.wr |=> ctl_q[DTC_B_OVF] == (lo_q[0] >= hi_q[0]);
	endproperty
	a_pwm_flag: assert property (p_pwm_flag) else $error("pwm flag off level");

	property p_pwm_wrap;
		pwm[0] && tick[0] && !bus.wr |=> lo_q[0] == $past(lo_q[0]) + 8'h01;
	endproperty
	a_pwm_wrap: assert property (p_pwm_wrap) else $error("pwm count skipped");

	property p_set_wins;
		ovf_set[0] && !pwm_owns[0] |=> ctl_q[DTC_B_OVF];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("overflow flag lost");

	property p_level_flag;
		!ctl_q[DTC_B_TYPE] && !ext_irq_pin[0] |=> ctl_q[DTC_B_EDGE];
	endproperty
	a_level_flag: assert property (p_level_flag) else $error("low level not flagged");

	property p_toggle;
		tog_q[1] && !pwm[1] && stp[1].ovf |=> tpin_out[1] != $past(tpin_out[1]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("pin not toggled");

	property p_split_quiet;
		u0_split && !hi3_ovf && !ctl_q[DTC_B_OVF + DTC_CTL_STRIDE] && !bus.wr
		|=> !ctl_q[DTC_B_OVF + DTC_CTL_STRIDE];
	endproperty
	a_split_quiet: assert property (p_split_quiet) else $error("unit 1 raised flag");

	property p_timer_clk;
		!ct_sel[1] && gate_open[1] && (mode[1] == DTC_M1) && !u0_split && !bus.wr
		|=> {hi_q[1], lo_q[1]} == $past({hi_q[1], lo_q[1]}) + 16'h0001;
	endproperty
	a_timer_clk: assert property (p_timer_clk) else $error("timer missed a clock");

	c_split: cover property (u0_split && hi3_ovf);
	c_pwm_rise: cover property (pwm[0] && !ctl_q[DTC_B_OVF] ##1 ctl_q[DTC_B_OVF]);
	c_toggle: cover property (tog_q[0] && stp[0].ovf);
	c_ext_count: cover property (ct_sel[1] && tick[1]);
endmodule : dtc_timer
`default_nettype wire

// >>> core/dtc_pkg.sv
// register map, bit positions and shared types of the dual timer/counter
`default_nettype none
package dtc_pkg;
	// register addresses on the plain register port
	localparam logic [7:0] DTC_A_CTL  = 8'h88; // timer_run_and_flag_control
	localparam logic [7:0] DTC_A_MODE = 8'h89; // timer_mode_register
	localparam logic [7:0] DTC_A_LO0  = 8'h8a; // unit0_low_byte, unit 1 at +1
	localparam logic [7:0] DTC_A_HI0  = 8'h8c; // unit0_high_byte, unit 1 at +1
	localparam logic [7:0] DTC_A_AUXM = 8'h8f; // timer_aux_mode_register
	localparam logic [7:0] DTC_A_TOG  = 8'ha2; // auxiliary_control_one toggle enables
	localparam logic [7:0] DTC_RST    = 8'h00;
	// control register: unit u fields sit at base + DTC_CTL_STRIDE*u
	localparam int DTC_B_TYPE     = 0;
	localparam int DTC_B_EDGE     = 1;
	localparam int DTC_B_RUN      = 4;
	localparam int DTC_B_OVF      = 5;
	localparam int DTC_CTL_STRIDE = 2;
	// mode register: unit u fields sit at base + DTC_MODE_STRIDE*u
	localparam int DTC_B_MHI         = 1;
	localparam int DTC_B_CT          = 2;
	localparam int DTC_B_GATE        = 3;
	localparam int DTC_MODE_STRIDE   = 4;
	// prescaler and byte limits
	localparam logic [4:0] DTC_PRE_MAX  = 5'h1f;
	localparam logic [7:0] DTC_BYTE_MAX = 8'hff;
	localparam logic [7:0] DTC_PWM_HI   = 8'h00;
	localparam logic [7:0] DTC_PWM_LO   = 8'hff;
	// mode field encodings; 100, 101 and 111 are reserved and hold the count
	typedef enum logic [2:0] {
		DTC_M0  = 3'b000,
		DTC_M1  = 3'b001,
		DTC_M2  = 3'b010,
		DTC_M3  = 3'b011,
		DTC_PWM = 3'b110
	} dtc_mode_type;
	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dtc_bus_type;
	// hardware clears when the interrupt controller vectors
	typedef struct packed {
		logic [1:0] ovf;
		logic [1:0] edge_flag;
	} dtc_ack_type;
	// one counting step of a unit
	typedef struct packed {
		logic [7:0] lo;
		logic [7:0] hi;
		logic       ovf;
	} dtc_cnt_type;
endpackage : dtc_pkg
`default_nettype wire

// >>> test/dtc_pins.sv
// model of the far side pins: count sources and external interrupt lines
`default_nettype none
module dtc_pins (
	// levels the bench asks the outside world to present
	input  wire logic [1:0] irq_lvl,
	input  wire logic [1:0] cnt_lvl,
	// device side of the shared timer pins
	input  wire logic [1:0] tpin_out,
	input  wire logic [1:0] tpin_oe,
	output logic [1:0]      ext_irq_pin,
	output logic [1:0]      tpin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// a pin the device drives shows its own level, so count source and toggle share it
	assign tpin_in     = (tpin_oe & tpin_out) | (~tpin_oe & cnt_lvl);
	// interrupt lines are plain levels, passed straight from irq_lvl with no pull-up
	assign ext_irq_pin = irq_lvl;
endmodule : dtc_pins
`default_nettype wire

// >>> test/dual_timer_counter_modes_bench.sv
// self-checking bench of the dual timer/counter
`default_nettype none
module dual_timer_counter_modes_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import dtc_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_n   = 1'b0;
	dtc_bus_type bus     = '0;
	dtc_ack_type ack     = '0;
	logic [1:0]  irq_lvl = 2'h3;
	logic [1:0]  cnt_lvl = 2'h3;
	logic [7:0]  rdata;
	logic [7:0]  ctl_flags;
	logic [1:0]  ext_irq_pin;
	logic [1:0]  tpin_in;
	logic [1:0]  tpin_out;
	logic [1:0]  tpin_oe;
	logic [7:0]  v;
	int          n_errors    = 0;
	int          checks_done = 0;
	int          hi_pin;
	int          hi_flag;
	// register rows: address, write data, expected read back
	logic [23:0] rows [12] = '{24'h89_55_55, 24'h8f_ff_11, 24'h8f_00_00, 24'ha2_00_00,
		24'h8a_a5_a5, 24'h8b_3c_3c, 24'h8c_5a_5a, 24'h8d_c3_c3, 24'h90_ff_00,
		24'h88_05_05, 24'h88_00_00, 24'h89_00_00};

	// free running 125 MHz clock
	always #4 clk_sys = ~clk_sys;

	dtc_timer u_dut (
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.bus         (bus),
		.rdata       (rdata),
		.ack         (ack),
		.ctl_flags   (ctl_flags),
		.ext_irq_pin (ext_irq_pin),
		.tpin_in     (tpin_in),
		.tpin_out    (tpin_out),
		.tpin_oe     (tpin_oe)
	);

	dtc_pins u_pins (
		.irq_lvl     (irq_lvl),
		.cnt_lvl     (cnt_lvl),
		.tpin_out    (tpin_out),
		.tpin_oe     (tpin_oe),
		.ext_irq_pin (ext_irq_pin),
		.tpin_in     (tpin_in)
	);

	// byte compare, the only kind of result this block gives
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one-cycle write strobe; returns on the edge that took it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask : wr

	// read strobe, data sampled in the single cycle it stands
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rdc

	// slow falling edges so the pin synchroniser sees each one
	task automatic pulse(input int u, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			cnt_lvl[u] <= 1'b0;
			repeat (2) @(posedge clk_sys);
			cnt_lvl[u] <= 1'b1;
			repeat (2) @(posedge clk_sys);
		end
		repeat (4) @(posedge clk_sys);
	endtask : pulse

	// one-cycle vectoring clear from the interrupt controller
	task automatic ackp(input dtc_ack_type a);
		@(posedge clk_sys);
		ack <= a;
		@(posedge clk_sys);
		ack <= '0;
	endtask : ackp

	// counts high cycles of unit 0 pin and flag over a window
	task automatic meas(input int n);
		hi_pin  = 0;
		hi_flag = 0;
		repeat (n) begin
			@(posedge clk_sys);
			#1;
			hi_pin  += (tpin_out[0] === 1'b1);
			hi_flag += (ctl_flags[5] === 1'b1);
		end
	endtask : meas

	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim

	// watchdog sized well past the whole sequence
	initial begin
		repeat (30000) @(posedge clk_sys);
		n_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_sim();
	end

	// main sequence
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		chk(ctl_flags, 8'h00);
		chk({4'h0, tpin_oe, tpin_out}, 8'h03);
		done("reset");
		for (int i = 0; i < 12; i++) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rdc(rows[i][23:16], rows[i][7:0]);
		end
		done("register table");
		// mode 0 counter: wrap, prescale by 32, stop and resume
		wr(DTC_A_MODE, 8'h04);
		wr(DTC_A_LO0, 8'hff);
		wr(DTC_A_HI0, 8'hff);
		wr(DTC_A_CTL, 8'h10);
		pulse(0, 1);
		rdc(DTC_A_LO0, 8'he0);
		rdc(DTC_A_HI0, 8'h00);
		rdc(DTC_A_CTL, 8'h30);
		pulse(0, 32);
		rdc(DTC_A_HI0, 8'h01);
		wr(DTC_A_CTL, 8'h00);
		pulse(0, 3);
		rdc(DTC_A_CTL, 8'h00);
		wr(DTC_A_CTL, 8'h10);
		pulse(0, 32);
		rdc(DTC_A_HI0, 8'h02);
		done("mode 0");
		// gate closed by a low interrupt pin, which also sets the level flag
		wr(DTC_A_MODE, 8'h0c);
		irq_lvl[0] <= 1'b0;
		pulse(0, 32);
		rdc(DTC_A_HI0, 8'h02);
		rdc(DTC_A_CTL, 8'h12);
		irq_lvl[0] <= 1'b1;
		pulse(0, 32);
		rdc(DTC_A_HI0, 8'h03);
		done("gate");
		// mode 2 reload and flag clear on vectoring
		wr(DTC_A_MODE, 8'h06);
		wr(DTC_A_LO0, 8'hff);
		wr(DTC_A_HI0, 8'h80);
		wr(DTC_A_CTL, 8'h10);
		pulse(0, 1);
		rdc(DTC_A_LO0, 8'h80);
		rdc(DTC_A_HI0, 8'h80);
		rdc(DTC_A_CTL, 8'h30);
		ackp('{ovf: 2'b01, edge_flag: 2'b00});
		rdc(DTC_A_CTL, 8'h10);
		done("mode 2");
		// unit 1 mode 1 behind its own gate, falling-edge interrupt type
		wr(DTC_A_MODE, 8'hd0);
		wr(DTC_A_LO0 + 8'h01, 8'hff);
		wr(DTC_A_HI0 + 8'h01, 8'h00);
		wr(DTC_A_CTL, 8'h44);
		irq_lvl[1] <= 1'b0;
		pulse(1, 1);
		rdc(DTC_A_LO0 + 8'h01, 8'hff);
		rdc(DTC_A_CTL, 8'h4c);
		irq_lvl[1] <= 1'b1;
		pulse(1, 1);
		ackp('{ovf: 2'b00, edge_flag: 2'b10});
		rdc(DTC_A_HI0 + 8'h01, 8'h01);
		rdc(DTC_A_LO0 + 8'h01, 8'h00);
		rdc(DTC_A_CTL, 8'h44);
		done("unit 1 mode 1");
		// mode 3 on both units, then unit 1 released from its own mode 3
		wr(DTC_A_MODE, 8'h70);
		wr(DTC_A_LO0 + 8'h01, 8'h00);
		wr(DTC_A_CTL, 8'h40);
		pulse(1, 3);
		rdc(DTC_A_LO0 + 8'h01, 8'h00);
		wr(DTC_A_MODE, 8'h33);
		wr(DTC_A_LO0, 8'h00);
		wr(DTC_A_HI0, 8'h00);
		repeat (300) @(posedge clk_sys);
		rdc(DTC_A_CTL, 8'hc0);
		rdc(DTC_A_LO0, 8'h00);
		rdc(DTC_A_LO0 + 8'h01, 8'h00);
		wr(DTC_A_MODE, 8'h13);
		repeat (10) @(posedge clk_sys);
		// one count per clock from the edge after the mode write: eleven by the read
		rdc(DTC_A_LO0 + 8'h01, 8'h0b);
		v = rdata;
		chk({7'h00, v !== 8'h00}, 8'h01);
		wr(DTC_A_CTL, 8'h00);
		done("mode 3");
		// pwm: 256-clock period, low for the high byte count, forced levels
		wr(DTC_A_MODE, 8'h02);
		wr(DTC_A_AUXM, 8'h01);
		wr(DTC_A_HI0, 8'h40);
		wr(DTC_A_CTL, 8'h10);
		meas(256);
		chk(8'(hi_pin), 8'hc0);
		chk(8'(hi_flag), 8'hc0);
		chk({6'h00, tpin_oe}, 8'h01);
		wr(DTC_A_HI0, 8'h00);
		meas(128);
		chk(8'(hi_pin), 8'h80);
		wr(DTC_A_HI0, 8'hff);
		meas(128);
		chk(8'(hi_pin), 8'h00);
		wr(DTC_A_CTL, 8'h00);
		done("pwm");
		// reserved mode 100 holds the count
		wr(DTC_A_MODE, 8'h04);
		wr(DTC_A_LO0, 8'h12);
		wr(DTC_A_CTL, 8'h10);
		pulse(0, 2);
		rdc(DTC_A_LO0, 8'h12);
		wr(DTC_A_CTL, 8'h00);
		wr(DTC_A_AUXM, 8'h00);
		done("reserved mode");
		// toggle output on unit 1 with the internal clock selected
		wr(DTC_A_MODE, 8'h10);
		wr(DTC_A_LO0 + 8'h01, 8'hf0);
		wr(DTC_A_HI0 + 8'h01, 8'hff);
		wr(DTC_A_TOG, 8'h02);
		#1;
		chk({6'h00, tpin_oe[1], tpin_out[1]}, 8'h03);
		wr(DTC_A_CTL, 8'h40);
		repeat (40) @(posedge clk_sys);
		#1;
		chk({6'h00, tpin_oe[1], tpin_out[1]}, 8'h02);
		done("toggle");
		// reset in mid-run: flags, toggled pin and count bytes return to rest
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		chk(ctl_flags, 8'h00);
		chk({4'h0, tpin_oe, tpin_out}, 8'h03);
		rdc(DTC_A_LO0 + 8'h01, 8'h00);
		done("mid-run reset");
		end_sim();
	end
endmodule : dual_timer_counter_modes_bench
`default_nettype wire
